// ===== hw/viu_pkg.sv
// constants, types and register map of the vectored interrupt unit
package viu_pkg;

  // ----------------------------------------------------------------
  // sources and vectors
  // ----------------------------------------------------------------
  localparam int NSRC = 8;
  localparam int SEL_W = 3;
  localparam int PC_W = 13;
  localparam logic [PC_W-1:0] VEC_BASE = 13'h0080;
  localparam logic [PC_W-1:0] VEC_LAST = 13'h00ff;
  localparam int VEC_STEP = 2;
  localparam int HALF_W = 4;

  // ----------------------------------------------------------------
  // entry latency in machine cycles
  // ----------------------------------------------------------------
  localparam logic [1:0] TAKE_DLY_ONE = 2'h2;
  localparam logic [1:0] TAKE_DLY_MULTI = 2'h3;

  // ----------------------------------------------------------------
  // apb register map, byte addresses
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_EN_LOW = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_EN_HIGH = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_EVT = 12'h00c;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 12'h010;
  localparam logic [3:0] EN_RESET = 4'h0;

  // state register fields
  localparam int ST_GIE_BIT = 8;
  localparam int ST_EIPEND_BIT = 9;
  localparam int ST_CTXV_BIT = 10;

  // event status bits
  localparam int NEVT = 3;
  localparam int EVT_ENTRY = 0;
  localparam int EVT_RETURN = 1;
  localparam int EVT_OVERRUN = 2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [8:0] dataPtr;
    logic       carry;
    logic       skip;
    logic [3:0] regA;
    logic [3:0] regB;
  } context_t;

  typedef struct packed {
    logic             enableIrqInstr;
    logic             disableIrqInstr;
    logic             returnFromIrqInstr;
    logic             done;
    logic             multi;
    logic             skipTest;
    logic [SEL_W-1:0] skipSel;
  } core_cmd_t;

  typedef struct packed {
    logic [3:0] timerUnder;
    logic       convDone;
    logic       serialDone;
  } src_evt_t;

  typedef enum logic {ST_IDLE, ST_WAIT} entry_state_t;

endpackage

// ===== hw/vectored_interrupt_unit.sv
// vectored interrupt unit: request flags, enables, priority, entry and return
module vectored_interrupt_unit (
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [viu_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire viu_pkg::core_cmd_t            coreCmd,
  input  wire viu_pkg::context_t             ctxIn,
  input  wire logic [viu_pkg::PC_W-1:0]      resumePc,
  input  wire logic                          extIrqPinA,
  input  wire logic                          extIrqPinB,
  input  wire viu_pkg::src_evt_t             srcEvt,
  output logic                               take,
  output logic [viu_pkg::PC_W-1:0]           vectorPc,
  output logic                               pushReq,
  output logic [viu_pkg::PC_W-1:0]           pushAddr,
  output logic                               popReq,
  output logic                               restore,
  output viu_pkg::context_t                  ctxOut,
  output logic                               skipHit,
  output logic                               irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // flag bit order: ext0, ext1, timer1..4, converter, serial
  logic [viu_pkg::NSRC-1:0]   reqFlag_reg;
  logic [viu_pkg::NSRC-1:0]   reqFlag_next;
  logic [3:0]                 irqEnableLow_reg;
  logic [3:0]                 irqEnableHigh_reg;
  logic                       globalIrqEnable_reg;
  logic                       irqEnablePend_reg;
  logic [1:0]                 pinPrev_reg;
  logic                       pinPrimed_reg;
  viu_pkg::entry_state_t      state_reg;
  logic [1:0]                 cnt_reg;
  logic                       take_reg;
  logic [viu_pkg::PC_W-1:0]   vector_reg;
  logic [viu_pkg::PC_W-1:0]   pushAddr_reg;
  logic                       popReq_reg;
  viu_pkg::context_t          irqContextSave_reg;
  logic                       ctxValid_reg;
  logic                       skipHit_reg;
  logic [viu_pkg::NEVT-1:0]   evt_reg;
  logic [viu_pkg::NEVT-1:0]   mask_reg;
  logic [31:0]                prdata_reg;

  logic [viu_pkg::NSRC-1:0]   enables;
  logic [viu_pkg::NSRC-1:0]   srcSet;
  logic [viu_pkg::NSRC-1:0]   eligible;
  logic [viu_pkg::NSRC-1:0]   takeHot;
  logic [viu_pkg::NSRC-1:0]   skipClr;
  logic [viu_pkg::SEL_W-1:0]  winner;
  logic                       anyElig;
  logic                       fire;
  logic                       skipOk;
  logic [viu_pkg::NEVT-1:0]   evtSet;
  logic                       wrAcc;
  logic                       rdSetup;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // lowest set index wins
  function automatic logic [viu_pkg::SEL_W-1:0] pick(
    input logic [viu_pkg::NSRC-1:0] v);
    logic [viu_pkg::SEL_W-1:0] r;
    r = '0;
    for (int i = viu_pkg::NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = viu_pkg::SEL_W'(i);
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [viu_pkg::ADDR_W-1:0] a);
    return a == viu_pkg::ADDR_EN_LOW || a == viu_pkg::ADDR_EN_HIGH ||
           a == viu_pkg::ADDR_STATE || a == viu_pkg::ADDR_EVT ||
           a == viu_pkg::ADDR_MASK;
  endfunction

  // ----------------------------------------------------------------
  // sources
  // ----------------------------------------------------------------
  assign enables = {irqEnableHigh_reg, irqEnableLow_reg};

  // first sample only primes the edge detector, so a pin high out of reset
  // does not fake an event
  assign srcSet = {srcEvt.serialDone, srcEvt.convDone, srcEvt.timerUnder,
                   {2{pinPrimed_reg}} &
                   ({extIrqPinB, extIrqPinA} ^ pinPrev_reg)};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pinPrev_reg <= 2'h0;
      pinPrimed_reg <= 1'b0;
    end else begin
      pinPrev_reg <= {extIrqPinB, extIrqPinA};
      pinPrimed_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // eligibility and priority
  // ----------------------------------------------------------------
  assign eligible = reqFlag_reg & enables &
                    {viu_pkg::NSRC{globalIrqEnable_reg}};
  assign anyElig = |eligible;
  assign winner = pick(eligible);
  assign fire = state_reg == viu_pkg::ST_WAIT && cnt_reg == 2'h1 && anyElig;
  assign takeHot = fire ? (viu_pkg::NSRC'(1) << winner) : '0;

  // skip clears only when the source enable is zero
  assign skipOk = coreCmd.skipTest && !enables[coreCmd.skipSel] &&
                  reqFlag_reg[coreCmd.skipSel];
  assign skipClr = skipOk ? (viu_pkg::NSRC'(1) << coreCmd.skipSel) : '0;

  // ----------------------------------------------------------------
  // request flags
  // ----------------------------------------------------------------
  // set term last so a same-cycle event survives the clear
  assign reqFlag_next = (reqFlag_reg & ~(takeHot | skipClr)) | srcSet;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqFlag_reg <= '0;
    end else begin
      reqFlag_reg <= reqFlag_next;
    end
  end

  // ----------------------------------------------------------------
  // global enable
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      globalIrqEnable_reg <= 1'b0;
      irqEnablePend_reg <= 1'b0;
    end else begin
      if (coreCmd.disableIrqInstr || fire) begin
        globalIrqEnable_reg <= 1'b0;
        irqEnablePend_reg <= 1'b0;
      end else if (coreCmd.enableIrqInstr) begin
        irqEnablePend_reg <= 1'b1;
      end else if (irqEnablePend_reg && coreCmd.done) begin
        globalIrqEnable_reg <= 1'b1;
        irqEnablePend_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // entry sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= viu_pkg::ST_IDLE;
      cnt_reg <= 2'h0;
    end else begin
      unique case (state_reg)
        viu_pkg::ST_IDLE: begin
          if (anyElig) begin
            state_reg <= viu_pkg::ST_WAIT;
            cnt_reg <= (coreCmd.multi ? viu_pkg::TAKE_DLY_MULTI
                                      : viu_pkg::TAKE_DLY_ONE) - 2'h1;
          end
        end
        viu_pkg::ST_WAIT: begin
          // a disable before the last wait cycle cancels the entry
          if (!anyElig || cnt_reg == 2'h1) begin
            state_reg <= viu_pkg::ST_IDLE;
          end
          cnt_reg <= cnt_reg - 2'h1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      take_reg <= 1'b0;
      vector_reg <= '0;
      pushAddr_reg <= '0;
    end else begin
      take_reg <= fire;
      if (fire) begin
        vector_reg <= viu_pkg::VEC_BASE +
                      viu_pkg::PC_W'(winner) * viu_pkg::PC_W'(viu_pkg::VEC_STEP);
        pushAddr_reg <= resumePc;
      end
    end
  end

  // ----------------------------------------------------------------
  // context save and return
  // ----------------------------------------------------------------
  // one stage only: a nested entry overwrites it and flags an overrun
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqContextSave_reg <= '0;
      ctxValid_reg <= 1'b0;
      popReq_reg <= 1'b0;
    end else begin
      popReq_reg <= coreCmd.returnFromIrqInstr;
      if (fire) begin
        irqContextSave_reg <= ctxIn;
        ctxValid_reg <= 1'b1;
      end else if (coreCmd.returnFromIrqInstr) begin
        ctxValid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      skipHit_reg <= 1'b0;
    end else begin
      skipHit_reg <= skipOk;
    end
  end

  // ----------------------------------------------------------------
  // apb slave and event status
  // ----------------------------------------------------------------
  assign wrAcc = psel && penable && pwrite && mapped(paddr);
  assign rdSetup = psel && !penable && !pwrite;
  assign evtSet = {fire && ctxValid_reg, coreCmd.returnFromIrqInstr, fire};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqEnableLow_reg <= viu_pkg::EN_RESET;
      irqEnableHigh_reg <= viu_pkg::EN_RESET;
      mask_reg <= '0;
    end else if (wrAcc) begin
      if (paddr == viu_pkg::ADDR_EN_LOW) begin
        irqEnableLow_reg <= pwdata[3:0];
      end
      if (paddr == viu_pkg::ADDR_EN_HIGH) begin
        irqEnableHigh_reg <= pwdata[3:0];
      end
      if (paddr == viu_pkg::ADDR_MASK) begin
        mask_reg <= pwdata[viu_pkg::NEVT-1:0];
      end
    end
  end

  // write one to clear; a new event beats the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_reg <= '0;
    end else if (wrAcc && paddr == viu_pkg::ADDR_EVT) begin
      evt_reg <= (evt_reg & ~pwdata[viu_pkg::NEVT-1:0]) | evtSet;
    end else begin
      evt_reg <= evt_reg | evtSet;
    end
  end

  // read data captured in the setup cycle, answered with no wait state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_reg <= '0;
    end else if (rdSetup) begin
      prdata_reg <= '0;
      unique case (paddr)
        viu_pkg::ADDR_EN_LOW: prdata_reg[3:0] <= irqEnableLow_reg;
        viu_pkg::ADDR_EN_HIGH: prdata_reg[3:0] <= irqEnableHigh_reg;
        viu_pkg::ADDR_STATE: begin
          prdata_reg[viu_pkg::NSRC-1:0] <= reqFlag_reg;
          prdata_reg[viu_pkg::ST_GIE_BIT] <= globalIrqEnable_reg;
          prdata_reg[viu_pkg::ST_EIPEND_BIT] <= irqEnablePend_reg;
          prdata_reg[viu_pkg::ST_CTXV_BIT] <= ctxValid_reg;
        end
        viu_pkg::ADDR_EVT: prdata_reg[viu_pkg::NEVT-1:0] <= evt_reg;
        viu_pkg::ADDR_MASK: prdata_reg[viu_pkg::NEVT-1:0] <= mask_reg;
        default: prdata_reg <= '0;
      endcase
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign irq = |(evt_reg & mask_reg);

  assign take = take_reg;
  assign pushReq = take_reg;
  assign vectorPc = vector_reg;
  assign pushAddr = pushAddr_reg;
  assign popReq = popReq_reg;
  assign restore = popReq_reg;
  assign ctxOut = irqContextSave_reg;
  assign skipHit = skipHit_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_TAKE_NEEDS_ALL: assert property (
    @(posedge clk) disable iff (!rst_n)
    take_reg |-> $past(globalIrqEnable_reg) && $past(reqFlag_reg & enables) != '0)
    else $error("entry without an eligible source");

  AST_DISABLE_CLEARS: assert property (
    @(posedge clk) disable iff (!rst_n)
    coreCmd.disableIrqInstr |=> !globalIrqEnable_reg)
    else $error("global enable set after disable");

  AST_ENTRY_CLEARS_GIE: assert property (
    @(posedge clk) disable iff (!rst_n)
    take_reg |-> !globalIrqEnable_reg && !irqEnablePend_reg)
    else $error("global enable survived entry");

  AST_EVENT_SETS: assert property (
    @(posedge clk) disable iff (!rst_n)
    srcSet != '0 |=> (reqFlag_reg & $past(srcSet)) == $past(srcSet))
    else $error("event lost");

  AST_FLAG_HOLDS: assert property (
    @(posedge clk) disable iff (!rst_n)
    ($past(reqFlag_reg) & ~reqFlag_reg & ~$past(takeHot | skipClr)) == '0)
    else $error("flag dropped without clear cause");

  AST_PRIORITY: assert property (
    @(posedge clk) disable iff (!rst_n)
    fire |-> (eligible & ((viu_pkg::NSRC'(1) << winner) - 1'b1)) == '0 &&
             eligible[winner])
    else $error("lower priority source served");

  AST_VEC_RANGE: assert property (
    @(posedge clk) disable iff (!rst_n)
    take_reg |-> vector_reg >= viu_pkg::VEC_BASE &&
                 vector_reg <= viu_pkg::VEC_LAST && !vector_reg[0])
    else $error("vector outside page-1 table");

  AST_SKIP_BLOCKED: assert property (
    @(posedge clk) disable iff (!rst_n)
    skipHit_reg |-> !$past(enables[coreCmd.skipSel]))
    else $error("skip honoured with enable set");

  AST_ONLY_SERVED: assert property (
    @(posedge clk) disable iff (!rst_n)
    fire |=> $countones($past(reqFlag_reg) & ~reqFlag_reg & ~$past(skipClr)) <= 1)
    else $error("entry cleared more than one flag");

  AST_CTX_SAVED: assert property (
    @(posedge clk) disable iff (!rst_n)
    take_reg |-> irqContextSave_reg == $past(ctxIn))
    else $error("context not saved on entry");

  AST_ENABLE_LATE: assert property (
    @(posedge clk) disable iff (!rst_n)
    coreCmd.enableIrqInstr && !coreCmd.disableIrqInstr && !globalIrqEnable_reg
    |=> !globalIrqEnable_reg)
    else $error("enable took effect too early");

  AST_LATENCY_TWO: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_reg == viu_pkg::ST_IDLE && anyElig && !coreCmd.multi ##1 anyElig
    |=> take_reg)
    else $error("entry not two cycles after conditions");

endmodule

// ===== sim/return_stack_model.sv
// return-address stack model on the core side of the interrupt unit
module return_stack_model (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     pushReq,
  input  wire logic [viu_pkg::PC_W-1:0] pushAddr,
  input  wire logic                     popReq,
  output logic      [viu_pkg::PC_W-1:0] popAddr,
  output logic                          popSeen
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // stack
  // ----------------------------------------------------------------
  logic [viu_pkg::PC_W-1:0] stackQ[$];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stackQ.delete();
      popSeen <= 1'b0;
      popAddr <= '0;
    end else begin
      popSeen <= popReq;
      if (pushReq) begin
        stackQ.push_back(pushAddr);
      end
      if (popReq && stackQ.size() > 0) begin
        popAddr <= stackQ.pop_back();
      end else begin
        // stale value scrambled so a missing pop cannot pass by luck
        popAddr <= ~popAddr;
      end
    end
  end
endmodule

// ===== sim/vectored_interrupt_unit_test.sv
// self-checking bench of the vectored interrupt unit
module vectored_interrupt_unit_test;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam logic [11:0] A_LO = viu_pkg::ADDR_EN_LOW;
  localparam logic [11:0] A_HI = viu_pkg::ADDR_EN_HIGH;
  localparam logic [11:0] A_ST = viu_pkg::ADDR_STATE;
  localparam logic [11:0] A_EV = viu_pkg::ADDR_EVT;
  logic                     clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0]              paddr;
  logic [31:0]              pwdata, prdata, lfsrState;
  viu_pkg::core_cmd_t       coreCmd;
  viu_pkg::context_t        ctxIn, ctxOut;
  viu_pkg::src_evt_t        srcEvt;
  logic [viu_pkg::PC_W-1:0] resumePc, vectorPc, pushAddr, popAddr;
  logic                     extIrqPinA, extIrqPinB, take, pushReq, popReq;
  logic                     restore, skipHit, irq, popSeen;
  int                       cyc, startCyc, takeCount, failCount, checks;

  vectored_interrupt_unit vectored_interrupt_unit_i (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .coreCmd(coreCmd),
    .ctxIn(ctxIn), .resumePc(resumePc), .extIrqPinA(extIrqPinA),
    .extIrqPinB(extIrqPinB), .srcEvt(srcEvt), .take(take), .vectorPc(vectorPc),
    .pushReq(pushReq), .pushAddr(pushAddr), .popReq(popReq), .restore(restore),
    .ctxOut(ctxOut), .skipHit(skipHit), .irq(irq));

  return_stack_model return_stack_model_i (.clk(clk), .rst_n(rst_n),
    .pushReq(pushReq), .pushAddr(pushAddr), .popReq(popReq), .popAddr(popAddr),
    .popSeen(popSeen));

  always @(posedge clk) begin
    cyc <= cyc + 1;
    takeCount <= takeCount + int'(take);
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one apb transfer; the request holds until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
    #1;
  endtask

  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask

  task automatic pulseCmd(input logic [8:0] c);
    @(posedge clk);
    coreCmd <= viu_pkg::core_cmd_t'(c);
    @(posedge clk);
    coreCmd <= '0;
  endtask

  task automatic enableGie();
    pulseCmd(9'h100);
    pulseCmd(9'h020);
  endtask

  task automatic raiseSrc(input int i, input logic m);
    @(posedge clk);
    if (i == 0) extIrqPinA <= ~extIrqPinA;
    else if (i == 1) extIrqPinB <= ~extIrqPinB;
    else srcEvt <= viu_pkg::src_evt_t'(6'(i < 6 ? (1 << i) : (1 << (7 - i))));
    coreCmd.multi <= m;
    #1 startCyc = cyc;
    @(posedge clk);
    srcEvt <= '0;
  endtask

  // waits for entry, checks it, then returns from the routine
  task automatic waitTake(input int i, input int dly);
    int n;
    n = 0;
    while (take !== 1'b1 && n < 12) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (dly >= 0) chk(32'(cyc - startCyc), 32'(dly));
    chk(pushReq, 1);
    chk(vectorPc, viu_pkg::VEC_BASE + 13'(viu_pkg::VEC_STEP * i));
    chk(pushAddr, resumePc);
    chk(ctxOut, ctxIn);
    pulseCmd(9'h040);
    #1 chk(restore, 1);
    n = 0;
    while (popSeen !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(popAddr, resumePc);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d failures=%0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, scenarios
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #30000;
    failCount++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] q;
    logic        e;
    {rst_n, psel, penable, pwrite, extIrqPinA, extIrqPinB} = '0;
    {paddr, pwdata, coreCmd, srcEvt, cyc, takeCount, failCount, checks} = '0;
    lfsrState = 32'h5f03;
    ctxIn = viu_pkg::context_t'(19'h2a5c3);
    resumePc = 13'h1234;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdChk(A_LO, 32'h0);
    rdChk(A_HI, 32'h0);
    apb(1'b0, 12'h0f0, 32'h0, q, e);
    chk(e, 1);
    wr(A_LO, 32'h5);
    wr(A_HI, 32'ha);
    rdChk(A_LO, 32'h5);
    rdChk(A_HI, 32'ha);
    wr(A_LO, 32'hf);
    wr(A_HI, 32'hf);
    // every source raised while the global enable is off
    for (int i = 0; i < 8; i++) raiseSrc(i, 1'b0);
    rdChk(A_ST, 32'h0ff);
    // done in the same cycle as the enable instruction does not count
    pulseCmd(9'h120);
    rdChk(A_ST, 32'h2ff);
    pulseCmd(9'h020);
    for (int i = 0; i < 8; i++) begin
      if (i > 0) enableGie();
      waitTake(i, -1);
      rdChk(A_ST, 32'(8'(8'hff << (i + 1))));
    end
    // event status, mask and interrupt line
    #1 chk(irq, 0);
    wr(viu_pkg::ADDR_MASK, 32'h1);
    chk(irq, 1);
    wr(A_EV, 32'h7);
    chk(irq, 0);
    rdChk(A_EV, 32'h0);
    // skip tests against enable bit and a same-cycle event
    wr(A_LO, 32'h0);
    raiseSrc(2, 1'b0);
    pulseCmd(9'h00a);
    #1 chk(skipHit, 1);
    rdChk(A_ST, 32'h0);
    raiseSrc(2, 1'b0);
    @(posedge clk);
    coreCmd <= viu_pkg::core_cmd_t'(9'h00a);
    srcEvt <= viu_pkg::src_evt_t'(6'h04);
    @(posedge clk);
    coreCmd <= '0;
    srcEvt <= '0;
    rdChk(A_ST, 32'h4);
    wr(A_LO, 32'h4);
    pulseCmd(9'h00a);
    #1 chk(skipHit, 0);
    rdChk(A_ST, 32'h4);
    // global enable on with a blocked source, then disable
    wr(A_LO, 32'h0);
    startCyc = takeCount;
    enableGie();
    repeat (6) @(posedge clk);
    chk(32'(takeCount - startCyc), 0);
    rdChk(A_ST, 32'h104);
    pulseCmd(9'h080);
    rdChk(A_ST, 32'h4);
    pulseCmd(9'h00a);
    // random sources, contexts and instruction lengths
    wr(A_LO, 32'hf);
    for (int r = 0; r < 8; r++) begin
      int idx;
      logic m;
      lfsrState = lfsrNext(lfsrNext(lfsrNext(lfsrState)));
      idx = 2 + int'(lfsrState[2:0]) % 6;
      m = lfsrState[3];
      @(posedge clk);
      ctxIn <= viu_pkg::context_t'(lfsrState[22:4]);
      resumePc <= lfsrState[31:19];
      enableGie();
      raiseSrc(idx, m);
      waitTake(idx, 1 + int'(m ? viu_pkg::TAKE_DLY_MULTI : viu_pkg::TAKE_DLY_ONE));
    end
    rdChk(A_EV, 32'h3);
    // nested entry while the save register still holds a context
    enableGie();
    raiseSrc(3, 1'b0);
    repeat (4) @(posedge clk);
    enableGie();
    raiseSrc(4, 1'b0);
    waitTake(4, 3);
    rdChk(A_EV, 32'h7);
    tally_and_finish();
  end
endmodule
